// *** rtl/effh_fifo.sv ***
// Transmit byte FIFO with registered read data
module effh_fifo #(
	parameter int unsigned W = 9,
	parameter int unsigned D = 32
) (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic [W-1:0] in_data_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	output logic [W-1:0] out_data_out,
	output logic out_valid_out,
	input wire logic out_ready_in
);
	localparam int unsigned AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0] wr_reg;
	logic [AW:0] rd_reg;
	logic [W-1:0] q_reg;
	logic qv_reg;

	// ----------------------------------------
	// Pointer decode
	// ----------------------------------------
	wire empty_w = (wr_reg == rd_reg);
	wire full_w = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire push_w = in_valid_in && !full_w;
	wire load_w = !empty_w && (!qv_reg || out_ready_in);

	assign in_ready_out = !full_w;
	assign out_data_out = q_reg;
	assign out_valid_out = qv_reg;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (push_w) begin
			mem[wr_reg[AW-1:0]] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			wr_reg <= '0;
			rd_reg <= '0;
			qv_reg <= 1'b0;
			q_reg <= '0;
		end else begin
			if (push_w) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (load_w) begin
				q_reg <= mem[rd_reg[AW-1:0]];
				rd_reg <= rd_reg + 1'b1;
				qv_reg <= 1'b1;
			end else if (out_ready_in) begin
				qv_reg <= 1'b0;
			end
		end
	end

endmodule

// *** rtl/effh_pkg.sv ***
// Shared constants and types for the Ethernet frame field handling block
package effh_pkg;

	// ----------------------------------------
	// Field values
	// ----------------------------------------
	localparam logic [7:0] EFFH_PRE_BYTE = 8'h55;
	localparam logic [7:0] EFFH_SFD_BYTE = 8'hd5;
	localparam logic [7:0] EFFH_ONES_BYTE = 8'hff;
	localparam logic [15:0] EFFH_TYPE_VLAN = 16'h8100;
	localparam logic [15:0] EFFH_TYPE_PAUSE = 16'h8808;

	// ----------------------------------------
	// Positions and counts
	// ----------------------------------------
	localparam logic [2:0] EFFH_PRE_LAST = 3'h6;
	localparam logic [2:0] EFFH_SFD_POS = 3'h7;
	localparam logic [2:0] EFFH_BIT_LAST = 3'h7;
	localparam logic [15:0] EFFH_DA_FIRST = 16'h0000;
	localparam logic [15:0] EFFH_DA_LAST = 16'h0005;
	localparam logic [15:0] EFFH_TYPE_HI = 16'h000c;
	localparam logic [15:0] EFFH_TYPE_LO = 16'h000d;
	localparam logic [15:0] EFFH_HDR_BYTES = 16'h000e;
	localparam logic [15:0] EFFH_IDX_MAX = 16'hffff;
	localparam int unsigned EFFH_FIFO_DEPTH = 32;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [7:0] EFFH_RST_BYTE = 8'h00;
	localparam logic [15:0] EFFH_RST_IDX = 16'h0000;
	localparam logic [5:0] EFFH_RST_FRAMES = 6'h00;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} effh_beat_t;

	typedef struct packed {
		logic [7:0] data;
		logic last;
		logic err;
		logic mcast;
		logic bcast;
		logic vlan;
		logic pause;
	} effh_rx_beat_t;

	typedef enum logic [2:0] {
		EFFH_TX_IDLE,
		EFFH_TX_PRE,
		EFFH_TX_SFD,
		EFFH_TX_DATA,
		EFFH_TX_FLUSH
	} effh_tx_state_t;

endpackage

// *** rtl/effh_top.sv ***
// Frame field handling: preamble and delimiter insertion, stripping and address checks
// Notes on behaviour
// - transmit puts seven 0x55 preamble bytes ahead of every frame when custom preamble mode is off.
// - receive drops all preamble bytes before the user side.
// - custom preamble mode sends user bytes in the preamble slots.
// - transmit inserts the delimiter right after the preamble.
// - receive drops the delimiter before frame data reach the user.
// - first octet bit 0 clear means unicast, set means multicast.
// - all-ones destination is broadcast; all address kinds pass alike.
// - addresses go out least significant bit first.
// - fields go in order, each byte least significant bit first.
// - destination address is first field on transmit and receive.
// - source address comes from the user and passes unaltered.
// - source address stays the second field in received data.
// - VLAN tagged frames with four extra bytes are accepted.
// - jumbo frames pass without any length rejection.
// - PAUSE frames are sent and received like any other.
// - control and framing functions are always present; custom preamble mode switches off preamble insertion and the receive preamble check.
// - framing and receive error detection work with any attached PHY.
module effh_top
	import effh_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic custom_pre_in,
	input wire effh_beat_t tx_beat_in,
	input wire logic tx_valid_in,
	output logic tx_ready_out,
	output logic tx_underrun_out,
	output logic phy_tx_bit_out,
	output logic phy_tx_en_out,
	input wire logic phy_rx_bit_in,
	input wire logic phy_rx_dv_in,
	input wire logic phy_rx_er_in,
	output effh_rx_beat_t rx_beat_out,
	output logic rx_valid_out,
	output logic rx_drop_out
);

	// ----------------------------------------
	// Transmit buffer
	// ----------------------------------------
	effh_beat_t fifo_beat;
	logic fifo_valid;
	logic fifo_pop;
	logic fifo_in_ready;
	logic [5:0] frames_reg;

	effh_fifo #(
		.W($bits(effh_beat_t)),
		.D(EFFH_FIFO_DEPTH)
	) effh_fifo_inst (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.in_data_in(tx_beat_in),
		.in_valid_in(tx_valid_in),
		.in_ready_out(fifo_in_ready),
		.out_data_out(fifo_beat),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_pop)
	);

	wire push_last_w = tx_valid_in && fifo_in_ready && tx_beat_in.last;
	wire pop_last_w = fifo_pop && fifo_beat.last;

	assign tx_ready_out = fifo_in_ready;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			frames_reg <= EFFH_RST_FRAMES;
		end else if (push_last_w && !pop_last_w) begin
			frames_reg <= frames_reg + 6'h01;
		end else if (pop_last_w && !push_last_w) begin
			frames_reg <= frames_reg - 6'h01;
		end
	end

	// ----------------------------------------
	// Transmit framing
	// ----------------------------------------
	effh_tx_state_t tx_state_reg, tx_state_next;
	logic [2:0] tx_bit_reg;
	logic [2:0] tx_pre_reg, tx_pre_next;
	logic [7:0] tx_sh_reg, tx_sh_next;
	logic tx_en_reg, tx_en_next;
	logic tx_last_reg, tx_last_next;
	logic tx_custom_reg, tx_custom_next;
	logic tx_under_reg, tx_under_next;

	wire tx_tick_w = tx_en_reg && (tx_bit_reg == EFFH_BIT_LAST);
	wire tx_start_w = fifo_valid && ((frames_reg != EFFH_RST_FRAMES) || !fifo_in_ready);
	wire tx_abort_state_w = tx_last_reg;

	always_comb begin
		tx_state_next = tx_state_reg;
		tx_pre_next = tx_pre_reg;
		tx_sh_next = tx_en_reg ? {1'b0, tx_sh_reg[7:1]} : tx_sh_reg;
		tx_en_next = tx_en_reg;
		tx_last_next = tx_last_reg;
		tx_custom_next = tx_custom_reg;
		tx_under_next = 1'b0;
		fifo_pop = 1'b0;
		case (tx_state_reg)
			EFFH_TX_IDLE: begin
				if (tx_start_w) begin
					tx_en_next = 1'b1;
					tx_pre_next = 3'h0;
					tx_custom_next = custom_pre_in;
					tx_state_next = EFFH_TX_PRE;
					if (custom_pre_in) begin
						fifo_pop = 1'b1;
						tx_sh_next = fifo_beat.data;
						tx_last_next = fifo_beat.last;
					end else begin
						tx_sh_next = EFFH_PRE_BYTE;
						tx_last_next = 1'b0;
					end
				end
			end
			EFFH_TX_PRE: begin
				if (tx_tick_w) begin
					if (tx_pre_reg == EFFH_PRE_LAST) begin
						tx_sh_next = EFFH_SFD_BYTE;
						tx_state_next = EFFH_TX_SFD;
					end else if (!tx_custom_reg) begin
						tx_pre_next = tx_pre_reg + 3'h1;
						tx_sh_next = EFFH_PRE_BYTE;
					end else if (fifo_valid && !tx_last_reg) begin
						tx_pre_next = tx_pre_reg + 3'h1;
						fifo_pop = 1'b1;
						tx_sh_next = fifo_beat.data;
						tx_last_next = fifo_beat.last;
					end else begin
						tx_en_next = 1'b0;
						tx_under_next = 1'b1;
						tx_state_next = tx_abort_state_w ? EFFH_TX_IDLE : EFFH_TX_FLUSH;
					end
				end
			end
			EFFH_TX_SFD: begin
				if (tx_tick_w) begin
					if (fifo_valid && !tx_last_reg) begin
						fifo_pop = 1'b1;
						tx_sh_next = fifo_beat.data;
						tx_last_next = fifo_beat.last;
						tx_state_next = EFFH_TX_DATA;
					end else begin
						tx_en_next = 1'b0;
						tx_under_next = 1'b1;
						tx_state_next = tx_abort_state_w ? EFFH_TX_IDLE : EFFH_TX_FLUSH;
					end
				end
			end
			EFFH_TX_DATA: begin
				if (tx_tick_w) begin
					if (tx_last_reg) begin
						tx_en_next = 1'b0;
						tx_state_next = EFFH_TX_IDLE;
					end else if (fifo_valid) begin
						fifo_pop = 1'b1;
						tx_sh_next = fifo_beat.data;
						tx_last_next = fifo_beat.last;
					end else begin
						tx_en_next = 1'b0;
						tx_under_next = 1'b1;
						tx_state_next = EFFH_TX_FLUSH;
					end
				end
			end
			EFFH_TX_FLUSH: begin
				if (fifo_valid) begin
					fifo_pop = 1'b1;
					if (fifo_beat.last) begin
						tx_state_next = EFFH_TX_IDLE;
					end
				end
			end
			default: begin
				tx_en_next = 1'b0;
				tx_state_next = EFFH_TX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			tx_state_reg <= EFFH_TX_IDLE;
			tx_bit_reg <= 3'h0;
			tx_pre_reg <= 3'h0;
			tx_sh_reg <= EFFH_RST_BYTE;
			tx_en_reg <= 1'b0;
			tx_last_reg <= 1'b0;
			tx_custom_reg <= 1'b0;
			tx_under_reg <= 1'b0;
		end else begin
			tx_state_reg <= tx_state_next;
			tx_bit_reg <= tx_en_reg ? tx_bit_reg + 3'h1 : 3'h0;
			tx_pre_reg <= tx_pre_next;
			tx_sh_reg <= tx_sh_next;
			tx_en_reg <= tx_en_next;
			tx_last_reg <= tx_last_next;
			tx_custom_reg <= tx_custom_next;
			tx_under_reg <= tx_under_next;
		end
	end

	assign phy_tx_bit_out = tx_sh_reg[0];
	assign phy_tx_en_out = tx_en_reg;
	assign tx_underrun_out = tx_under_reg;

	// ----------------------------------------
	// Receive byte alignment
	// ----------------------------------------
	logic [2:0] rx_bit_reg;
	logic [7:0] rx_sh_reg;
	logic rx_act_reg;
	logic rx_custom_reg;

	wire [7:0] rx_byte_w = {phy_rx_bit_in, rx_sh_reg[7:1]};
	wire rx_done_w = phy_rx_dv_in && (rx_bit_reg == EFFH_BIT_LAST);
	wire rx_end_w = rx_act_reg && !phy_rx_dv_in;
	wire rx_start_w = !rx_act_reg && phy_rx_dv_in;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_bit_reg <= 3'h0;
			rx_sh_reg <= EFFH_RST_BYTE;
			rx_act_reg <= 1'b0;
			rx_custom_reg <= 1'b0;
		end else begin
			rx_bit_reg <= phy_rx_dv_in ? rx_bit_reg + 3'h1 : 3'h0;
			rx_sh_reg <= phy_rx_dv_in ? rx_byte_w : EFFH_RST_BYTE;
			rx_act_reg <= phy_rx_dv_in;
			if (rx_start_w) begin
				rx_custom_reg <= custom_pre_in;
			end
		end
	end

	// ----------------------------------------
	// Receive stripping and checks
	// ----------------------------------------
	logic [2:0] rx_pre_reg;
	logic rx_sync_reg;
	logic rx_bad_reg;
	logic [15:0] rx_idx_reg;
	logic rx_hold_reg;
	logic [7:0] rx_hold_data_reg;
	logic rx_mcast_reg;
	logic rx_bcast_reg;
	logic [7:0] rx_type_hi_reg;
	logic rx_vlan_reg;
	logic rx_pause_reg;

	wire rx_pre_byte_w = rx_done_w && !rx_sync_reg && (rx_pre_reg != EFFH_SFD_POS);
	wire rx_sfd_byte_w = rx_done_w && !rx_sync_reg && (rx_pre_reg == EFFH_SFD_POS);
	wire rx_body_w = rx_done_w && rx_sync_reg && !rx_bad_reg;
	wire rx_pre_bad_w = rx_pre_byte_w && !rx_custom_reg && (rx_byte_w != EFFH_PRE_BYTE);
	wire rx_sfd_ok_w = rx_sfd_byte_w && (rx_byte_w == EFFH_SFD_BYTE);
	wire rx_sfd_bad_w = rx_sfd_byte_w && !rx_sfd_ok_w;
	wire rx_phy_err_w = phy_rx_dv_in && phy_rx_er_in;
	wire rx_ones_w = (rx_byte_w == EFFH_ONES_BYTE);
	wire [15:0] rx_type_w = {rx_type_hi_reg, rx_byte_w};
	wire rx_short_w = (rx_idx_reg < EFFH_HDR_BYTES);
	wire rx_end_err_w = rx_bad_reg || (rx_bit_reg != 3'h0) || rx_short_w;
	wire rx_emit_mid_w = rx_body_w && rx_hold_reg;
	wire rx_emit_end_w = rx_end_w && rx_hold_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in || rx_end_w) begin
			rx_pre_reg <= 3'h0;
			rx_sync_reg <= 1'b0;
			rx_bad_reg <= 1'b0;
			rx_idx_reg <= EFFH_RST_IDX;
			rx_hold_reg <= 1'b0;
		end else begin
			if (rx_pre_byte_w) begin
				rx_pre_reg <= rx_pre_reg + 3'h1;
			end
			if (rx_sfd_ok_w) begin
				rx_sync_reg <= 1'b1;
			end
			if (rx_pre_bad_w || rx_sfd_bad_w || rx_phy_err_w) begin
				rx_bad_reg <= 1'b1;
			end
			if (rx_body_w) begin
				rx_hold_reg <= 1'b1;
				if (rx_idx_reg != EFFH_IDX_MAX) begin
					rx_idx_reg <= rx_idx_reg + 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_hold_data_reg <= EFFH_RST_BYTE;
			rx_mcast_reg <= 1'b0;
			rx_bcast_reg <= 1'b0;
			rx_type_hi_reg <= EFFH_RST_BYTE;
			rx_vlan_reg <= 1'b0;
			rx_pause_reg <= 1'b0;
		end else if (rx_body_w) begin
			rx_hold_data_reg <= rx_byte_w;
			if (rx_idx_reg == EFFH_DA_FIRST) begin
				rx_mcast_reg <= rx_byte_w[0];
				rx_bcast_reg <= rx_ones_w;
				rx_vlan_reg <= 1'b0;
				rx_pause_reg <= 1'b0;
			end else if (rx_idx_reg <= EFFH_DA_LAST) begin
				rx_bcast_reg <= rx_bcast_reg && rx_ones_w;
			end
			if (rx_idx_reg == EFFH_TYPE_HI) begin
				rx_type_hi_reg <= rx_byte_w;
			end
			if (rx_idx_reg == EFFH_TYPE_LO) begin
				rx_vlan_reg <= (rx_type_w == EFFH_TYPE_VLAN);
				rx_pause_reg <= (rx_type_w == EFFH_TYPE_PAUSE);
			end
		end
	end

	// ----------------------------------------
	// Receive output stage
	// ----------------------------------------
	effh_rx_beat_t rx_out_reg;
	logic rx_valid_reg;
	logic rx_drop_reg;

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			rx_out_reg <= '0;
			rx_valid_reg <= 1'b0;
			rx_drop_reg <= 1'b0;
		end else begin
			rx_valid_reg <= rx_emit_mid_w || rx_emit_end_w;
			rx_drop_reg <= rx_end_w && !rx_hold_reg;
			if (rx_emit_mid_w || rx_emit_end_w) begin
				rx_out_reg.data <= rx_hold_data_reg;
				rx_out_reg.last <= rx_emit_end_w;
				rx_out_reg.err <= rx_emit_end_w && rx_end_err_w;
				rx_out_reg.mcast <= rx_mcast_reg;
				rx_out_reg.bcast <= rx_bcast_reg;
				rx_out_reg.vlan <= rx_vlan_reg;
				rx_out_reg.pause <= rx_pause_reg;
			end
		end
	end

	assign rx_beat_out = rx_out_reg;
	assign rx_valid_out = rx_valid_reg;
	assign rx_drop_out = rx_drop_reg;

endmodule

// *** verif/effh_phy_model.sv ***
// Serial PHY partner model for the frame field block
module effh_phy_model (
	input wire logic clk_in,
	input wire logic phy_tx_bit_in,
	input wire logic phy_tx_en_in,
	output logic phy_rx_bit_out,
	output logic phy_rx_dv_out,
	output logic phy_rx_er_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] tx_q[$];
	logic [7:0] sh_reg;
	int n_bits;
	initial begin
		phy_rx_bit_out = 1'b0;
		phy_rx_dv_out = 1'b0;
		phy_rx_er_out = 1'b0;
	end
	// ----------------------------------------
	// Wire capture, LSB first
	// ----------------------------------------
	always @(negedge clk_in) begin
		if (phy_tx_en_in === 1'b1) begin
			sh_reg = {phy_tx_bit_in, sh_reg[7:1]};
			n_bits++;
			if (n_bits == 8) begin
				tx_q.push_back(sh_reg);
				n_bits = 0;
			end
		end else begin
			n_bits = 0;
		end
	end
	// ----------------------------------------
	// Frame send, driven at the edge
	// ----------------------------------------
	task automatic send(input logic [7:0] b[$], input logic er);
		for (int i = 0; i < b.size() * 8; i++) begin
			@(posedge clk_in);
			phy_rx_dv_out <= 1'b1;
			phy_rx_bit_out <= b[i / 8][i % 8];
			// Error flagged on the final bit only
			phy_rx_er_out <= er && (i == b.size() * 8 - 1);
		end
		@(posedge clk_in);
		phy_rx_dv_out <= 1'b0;
		phy_rx_er_out <= 1'b0;
		phy_rx_bit_out <= ~phy_rx_bit_out;
		@(posedge clk_in);
	endtask
endmodule

// *** verif/effh_top_asserts.sv ***
// Port checks for the frame field block
module effh_top_asserts
	import effh_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic custom_pre_in,
	input wire logic phy_tx_bit_out,
	input wire logic phy_tx_en_out,
	input wire logic phy_rx_dv_in,
	input wire effh_rx_beat_t rx_beat_out,
	input wire logic rx_valid_out,
	input wire logic rx_drop_out
);
	logic [15:0] en_cnt_reg;
	logic [15:0] dv_cnt_reg;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			en_cnt_reg <= 16'h0000;
			dv_cnt_reg <= 16'h0000;
		end else begin
			en_cnt_reg <= phy_tx_en_out ? en_cnt_reg + {15'h0000, ~&en_cnt_reg} : 16'h0000;
			dv_cnt_reg <= phy_rx_dv_in ? dv_cnt_reg + {15'h0000, ~&dv_cnt_reg} : 16'h0000;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	AST_PRE_BITS: assert property (
		phy_tx_en_out && !custom_pre_in && en_cnt_reg < 16'h0038 |->
		phy_tx_bit_out == ~en_cnt_reg[0]) else $error("Preamble bit wrong");
	AST_SFD_BITS: assert property (
		phy_tx_en_out && en_cnt_reg[15:3] == 13'h0007 |->
		phy_tx_bit_out == EFFH_SFD_BYTE[en_cnt_reg[2:0]]) else $error("Delimiter bit wrong");
	AST_EN_LEN: assert property (
		$fell(phy_tx_en_out) |-> en_cnt_reg >= 16'h0048) else $error("Frame too short");
	AST_RX_DELAY: assert property (
		rx_valid_out && $past(phy_rx_dv_in) |->
		(dv_cnt_reg >= 16'h0050 && dv_cnt_reg[2:0] == 3'h0) || &dv_cnt_reg)
		else $error("Byte delivered off schedule");
	AST_RX_MID: assert property (
		rx_valid_out && !rx_beat_out.last |-> $past(phy_rx_dv_in)) else $error("Stray byte");
	AST_RX_LAST: assert property (
		rx_valid_out && rx_beat_out.last |-> $past(phy_rx_dv_in, 2) && !$past(phy_rx_dv_in))
		else $error("Last byte mistimed");
	AST_DROP_TIME: assert property (
		rx_drop_out |-> $past(phy_rx_dv_in, 2) && !$past(phy_rx_dv_in))
		else $error("Drop mistimed");
	AST_DROP_EXCL: assert property (
		rx_drop_out |-> !rx_valid_out) else $error("Drop with data");
	COV_TX: cover property ($fell(phy_tx_en_out));
	COV_RX: cover property (rx_valid_out && rx_beat_out.last);
	COV_DROP: cover property (rx_drop_out);
endmodule

bind effh_top effh_top_asserts effh_top_asserts_inst (.clk_in(clk_in), .srst_in(srst_in),
	.custom_pre_in(custom_pre_in), .phy_tx_bit_out(phy_tx_bit_out),
	.phy_tx_en_out(phy_tx_en_out), .phy_rx_dv_in(phy_rx_dv_in), .rx_beat_out(rx_beat_out),
	.rx_valid_out(rx_valid_out), .rx_drop_out(rx_drop_out));

// *** verif/effh_top_tb.sv ***
// Self-checking bench for the frame field block
`define CHK(got, exp) begin \
	n_tests++; \
	if ((got) !== (exp)) begin \
		fails++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
	end \
end

module effh_top_tb
	import effh_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	typedef logic [7:0] effh_bq_t[$];
	logic clk_in, srst_in, custom_pre_in, tx_valid_in, tx_ready_out, tx_underrun_out;
	logic phy_tx_bit_out, phy_tx_en_out, phy_rx_bit, phy_rx_dv, phy_rx_er;
	logic rx_valid_out, rx_drop_out;
	effh_beat_t tx_beat_in;
	effh_rx_beat_t rx_beat_out;
	effh_rx_beat_t rx_q[$];
	int fails, n_tests, drops, unders, cycles;

	effh_top effh_top_inst (.clk_in(clk_in), .srst_in(srst_in), .custom_pre_in(custom_pre_in),
		.tx_beat_in(tx_beat_in), .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out),
		.tx_underrun_out(tx_underrun_out), .phy_tx_bit_out(phy_tx_bit_out),
		.phy_tx_en_out(phy_tx_en_out), .phy_rx_bit_in(phy_rx_bit), .phy_rx_dv_in(phy_rx_dv),
		.phy_rx_er_in(phy_rx_er), .rx_beat_out(rx_beat_out), .rx_valid_out(rx_valid_out),
		.rx_drop_out(rx_drop_out));
	effh_phy_model effh_phy_model_inst (.clk_in(clk_in), .phy_tx_bit_in(phy_tx_bit_out),
		.phy_tx_en_in(phy_tx_en_out), .phy_rx_bit_out(phy_rx_bit), .phy_rx_dv_out(phy_rx_dv),
		.phy_rx_er_out(phy_rx_er));

	initial begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	always @(negedge clk_in) begin
		if (rx_valid_out === 1'b1) rx_q.push_back(rx_beat_out);
		if (rx_drop_out === 1'b1) drops++;
		if (tx_underrun_out === 1'b1) unders++;
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			fails++;
			test_done();
		end
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic effh_bq_t body_of(logic [7:0] da, logic [7:0] hi, logic [7:0] lo, int n);
		effh_bq_t b;
		for (int i = 0; i < n; i++) b.push_back(i < 6 ? da : i == 12 ? hi : i == 13 ? lo : 8'(i));
		return b;
	endfunction
	task automatic tx_frame(input effh_bq_t b, input logic cust);
		effh_bq_t e;
		int u0;
		u0 = unders;
		for (int i = 0; i < 7; i++) e.push_back(cust ? b[i] : EFFH_PRE_BYTE);
		e.push_back(EFFH_SFD_BYTE);
		for (int i = cust ? 7 : 0; i < b.size(); i++) e.push_back(b[i]);
		effh_phy_model_inst.tx_q.delete();
		custom_pre_in <= cust;
		for (int i = 0; i < b.size(); i++) begin
			tx_beat_in <= '{last: i == b.size() - 1, data: b[i]};
			tx_valid_in <= 1'b1;
			@(negedge clk_in);
			while (tx_ready_out !== 1'b1) @(negedge clk_in);
			@(posedge clk_in);
		end
		tx_valid_in <= 1'b0;
		for (int k = 0; k < 3000 && effh_phy_model_inst.tx_q.size() < e.size(); k++)
			@(posedge clk_in);
		repeat (4) @(posedge clk_in);
		custom_pre_in <= 1'b0;
		`CHK(unders - u0, 0)
		`CHK(effh_phy_model_inst.tx_q.size(), e.size())
		foreach (e[i]) `CHK(effh_phy_model_inst.tx_q[i], e[i])
	endtask
	task automatic rx_frame(input logic cust, input logic [7:0] sfd, input effh_bq_t body,
		input logic er, input logic [4:0] flags, input int n_drop);
		effh_bq_t a;
		int d0;
		d0 = drops;
		rx_q.delete();
		for (int i = 0; i < 7; i++) a.push_back(cust ? 8'h30 + 8'(i) : EFFH_PRE_BYTE);
		a.push_back(sfd);
		a = {a, body};
		custom_pre_in <= cust;
		effh_phy_model_inst.send(a, er);
		repeat (3) @(posedge clk_in);
		custom_pre_in <= 1'b0;
		`CHK(rx_q.size(), n_drop != 0 ? 0 : body.size())
		`CHK(drops - d0, n_drop)
		foreach (rx_q[i]) `CHK(rx_q[i].data, body[i])
		if (rx_q.size() != 0) `CHK(rx_q[$][5:0], {1'b1, flags})
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic sc_tx_long();
		tx_frame(body_of(EFFH_ONES_BYTE, 8'h88, 8'h08, 40), 1'b0);
	endtask
	task automatic sc_tx_under();
		effh_bq_t b, e;
		int u0;
		b = body_of(8'h04, 8'h08, 8'h00, 40);
		u0 = unders;
		for (int i = 0; i < 7; i++) e.push_back(EFFH_PRE_BYTE);
		e.push_back(EFFH_SFD_BYTE);
		for (int i = 0; i < 33; i++) e.push_back(b[i]);
		effh_phy_model_inst.tx_q.delete();
		for (int i = 0; i < b.size(); i++) begin
			if (i == 33) begin
				tx_valid_in <= 1'b0;
				for (int k = 0; k < 1000 && unders == u0; k++) @(posedge clk_in);
				@(posedge clk_in);
			end
			tx_beat_in <= '{last: i == b.size() - 1, data: b[i]};
			tx_valid_in <= 1'b1;
			@(negedge clk_in);
			while (tx_ready_out !== 1'b1) @(negedge clk_in);
			@(posedge clk_in);
		end
		tx_valid_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		`CHK(unders - u0, 1)
		`CHK(effh_phy_model_inst.tx_q.size(), e.size())
		foreach (e[i]) `CHK(effh_phy_model_inst.tx_q[i], e[i])
	endtask
	task automatic sc_tx_custom();
		tx_frame(body_of(8'h02, 8'h08, 8'h00, 16), 1'b1);
	endtask
	task automatic sc_rx_pause();
		rx_frame(1'b0, EFFH_SFD_BYTE, body_of(8'hff, 8'h88, 8'h08, 18), 1'b0, 5'h0d, 0);
	endtask
	task automatic sc_rx_vlan();
		rx_frame(1'b1, EFFH_SFD_BYTE, body_of(8'h02, 8'h81, 8'h00, 22), 1'b0, 5'h02, 0);
	endtask
	task automatic sc_rx_jumbo();
		rx_frame(1'b0, EFFH_SFD_BYTE, body_of(8'h01, 8'h00, 8'h2e, 1520), 1'b0, 5'h08, 0);
	endtask
	task automatic sc_rx_bad();
		rx_frame(1'b0, 8'hd4, body_of(8'hff, 8'h88, 8'h08, 18), 1'b0, 5'h0d, 1);
		rx_frame(1'b0, EFFH_SFD_BYTE, body_of(8'hff, 8'h88, 8'h08, 18), 1'b1, 5'h1d, 0);
		rx_frame(1'b0, EFFH_SFD_BYTE, body_of(8'hff, 8'h00, 8'h00, 10), 1'b0, 5'h1c, 0);
	endtask
	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		srst_in = 1'b1;
		custom_pre_in = 1'b0;
		tx_valid_in = 1'b0;
		tx_beat_in = '0;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		sc_tx_long();
		sc_tx_under();
		sc_tx_custom();
		sc_rx_pause();
		sc_rx_vlan();
		sc_rx_jumbo();
		sc_rx_bad();
		test_done();
	end
endmodule
